// ---- adcsq_regs.svh ----
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// ----------------------------------------------------------------------
// Channel and data bus layout
// ----------------------------------------------------------------------
// Number of simultaneously sampled channels.
`define ADCSQ_CH_NUM          4
// Width of one conversion result.
`define ADCSQ_DATA_W          12
// Field of the data bus that programs the channel select register.
`define ADCSQ_CSR_LSB         0
`define ADCSQ_CSR_MSB         3
// Reset value of the channel select register.
`define ADCSQ_CSR_RESET       4'h0
// Result slot that the output pointer addresses after a start.
`define ADCSQ_FIRST_SLOT      2'h0
// Value of the hardware/software select pin that picks the register.
`define ADCSQ_SEL_SOFTWARE    1'b1
// Value of the clock source select pin that picks the external clock.
`define ADCSQ_CLK_EXTERNAL    1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Conversion clock periods needed for one channel.
`define ADCSQ_CONV_CLKS       14
// System clock period in nanoseconds.
`define ADCSQ_SYS_PERIOD_NS   10
// Period of the internal conversion clock in nanoseconds.
`define ADCSQ_INT_PERIOD_NS   118
// Internal conversion clock as a count of system clocks, rounded down.
`define ADCSQ_INT_DIV         (`ADCSQ_INT_PERIOD_NS / `ADCSQ_SYS_PERIOD_NS)

`endif

// ---- adcsq_pkg.sv ----
package adcsq_pkg;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  // Idle waits for a start edge; convert works through the channel mask.
  typedef enum logic [0:0]
  {
    ADCSQ_IDLE    = 1'b0,
    ADCSQ_CONVERT = 1'b1
  } adcsq_state_t;

endpackage : adcsq_pkg

// ---- adcsq_sync.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------------
module adcsq_sync
#(
  parameter int          WIDTH    = 1,
  parameter logic [63:0] RST_VAL  = 64'h0
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // First stage; read only by the second stage to contain metastability.
  logic [WIDTH-1:0] meta_q;

  // Both stages reset to the idle level of the pin.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL[WIDTH-1:0];
      q      <= RST_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : adcsq_sync

// ---- adcsq_conv_timer.sv ----
`timescale 1ns/100ps
`include "adcsq_regs.svh"

// ----------------------------------------------------------------------
// Per-channel conversion timer
// ----------------------------------------------------------------------
// Counts conversion clock ticks and pulses done once CYCLES have passed.
module adcsq_conv_timer
#(
  parameter int CYCLES = `ADCSQ_CONV_CLKS
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic run,
  input  wire logic tick,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  // Ticks counted so far in the current channel.
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  // The last tick of a channel completes it.
  wire           last_tick = run & tick & (cnt_q == LAST);

  assign done  = last_tick;
  assign cnt_d = (clear | last_tick) ? '0 :
                 (run & tick)        ? cnt_q + CW'(1) : cnt_q;

  // Counter restarts on clear so a new sequence never inherits ticks.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule : adcsq_conv_timer

// ---- adcsq_top.sv ----
`timescale 1ns/100ps
`include "adcsq_regs.svh"

// Overview of operation
// - Busy rises at start, falls after last channel
// - First flag high while pointer at slot one
// - Start edge holds all track/holds, starts conversion
// - Channel selection latched at start edge only
// - Reads and writes need chip select low
// - Data outputs enabled only with read, select low
// - Write rising edge loads low nibble into register
// - Select low: sequence from hardware select pins
// - Select high: sequence from channel select register
// - Standby input low enters power saving state
// - Register bit 0 is channel 1, bit 3 channel 4
// - End-of-conversion pulses low per finished channel
// - Each channel takes fourteen conversion clocks
// - Clock source select picks internal or external clock
module adcsq_top
#(
  parameter int CH_NUM    = `ADCSQ_CH_NUM,
  parameter int DATA_W    = `ADCSQ_DATA_W,
  parameter int CONV_CLKS = `ADCSQ_CONV_CLKS,
  parameter int INT_DIV   = `ADCSQ_INT_DIV
)
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              conversion_start_n,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [CH_NUM-1:0] hw_channel_select,
  input  wire logic              hw_sw_select,
  input  wire logic              standby_n,
  input  wire logic              clock_source_select,
  input  wire logic              external_conversion_clock,
  input  wire logic [CH_NUM-1:0] data_bus_low_nibble,
  input  wire logic [DATA_W-1:0] sample_code,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  output logic                   busy,
  output logic                   eoc_n,
  output logic                   first_result_flag,
  output logic                   track_hold_hold,
  output logic      [1:0]        active_channel,
  output logic                   standby_active
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Reset asserts at once and releases through two flops, so every register
  // reset by rst_n leaves reset on the same clean edge.
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // All host pins arrive asynchronously; chip select, read and write idle high, start idles low.
  logic [3:0]        strb_s;      // {start, cs, rd, wr} after two flops.
  logic [CH_NUM-1:0] hw_sel_s;    // Hardware channel select pins.
  logic [CH_NUM-1:0] bus_s;       // Low nibble of the data bus.
  logic [3:0]        misc_s;      // {hw/sw, standby, clk src, ext clk}.

  adcsq_sync #(.WIDTH(4), .RST_VAL(64'h7)) u_sync_strb
  (
    .clk (clk),
    .rst_n (rst_n),
    .d   ({conversion_start_n, cs_n, rd_n, wr_n}),
    .q   (strb_s)
  );

  // The data nibble takes the same two flops as the write strobe, so the
  // value seen at the strobe edge is the one the host set up for it.
  adcsq_sync #(.WIDTH(2 * CH_NUM), .RST_VAL(64'h0)) u_sync_bus
  (
    .clk (clk),
    .rst_n (rst_n),
    .d   ({hw_channel_select, data_bus_low_nibble}),
    .q   ({hw_sel_s, bus_s})
  );

  adcsq_sync #(.WIDTH(4), .RST_VAL(64'h4)) u_sync_misc
  (
    .clk (clk),
    .rst_n (rst_n),
    .d   ({hw_sw_select, standby_n, clock_source_select, external_conversion_clock}),
    .q   (misc_s)
  );

  wire start_s   = strb_s[3];
  wire cs_s      = strb_s[2];
  wire rd_s      = strb_s[1];
  wire wr_s      = strb_s[0];
  wire hwsw_s    = misc_s[3];
  wire standby_n_n_s  = misc_s[2];
  wire clksrc_s  = misc_s[1];
  wire extclk_s  = misc_s[0];

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  // Previous synchronised levels, used to find rising edges.
  logic start_prev_q;
  logic rd_prev_q;
  logic wr_prev_q;
  logic extclk_prev_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_prev_q  <= 1'b1;
      rd_prev_q     <= 1'b1;
      wr_prev_q     <= 1'b1;
      extclk_prev_q <= 1'b0;
    end
    else
    begin
      start_prev_q  <= start_s;
      rd_prev_q     <= rd_s;
      wr_prev_q     <= wr_s;
      extclk_prev_q <= extclk_s;
    end
  end

  // Start on a low-to-high edge; ignored in standby and while busy.
  wire start_edge = start_s & ~start_prev_q & standby_n_n_s;
  // A read ends when read goes high with chip select still low.
  wire read_end   = rd_s & ~rd_prev_q & ~cs_s;
  // A write lands on the rising write edge, selected and not reading.
  wire write_edge = wr_s & ~wr_prev_q & ~cs_s & rd_s;
  wire ext_tick   = extclk_s & ~extclk_prev_q;

  // ----------------------------------------------------------------------
  // Channel select register
  // ----------------------------------------------------------------------
  // Bit n enables channel n+1, so bit 0 is the first channel.
  logic [CH_NUM-1:0] csr_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      csr_q <= `ADCSQ_CSR_RESET;
    else if (write_edge)
      csr_q <= bus_s[`ADCSQ_CSR_MSB:`ADCSQ_CSR_LSB];
  end

  // Source of the sequence: pins or register, chosen by the select pin.
  wire [CH_NUM-1:0] sel_mask = (hwsw_s == `ADCSQ_SEL_SOFTWARE) ?
                               csr_q :
                               hw_sel_s;

  // ----------------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------------
  // The internal clock is a divided system clock. The external one is only
  // as fast as its synchronised edges allow, i.e. at most half the rate.
  localparam int DW = $clog2(INT_DIV + 1);
  logic [DW-1:0] div_q;
  wire           int_tick = (div_q == DW'(INT_DIV - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= '0;
    else if (int_tick)
      div_q <= '0;
    else
      div_q <= div_q + DW'(1);
  end

  wire conv_tick = (clksrc_s == `ADCSQ_CLK_EXTERNAL) ? ext_tick : int_tick;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  adcsq_pkg::adcsq_state_t state_q;
  adcsq_pkg::adcsq_state_t state_d;
  logic [CH_NUM-1:0] rem_q;       // Channels still to convert.
  logic [CH_NUM-1:0] rem_d;
  logic [2:0]        nres_q;      // Results stored in this sequence.
  logic [2:0]        nres_d;
  logic              eoc_n_q;     // End-of-conversion output flop.
  logic              chan_done;   // Timer reports a finished channel.
  logic [1:0]        cur_ch;      // Lowest channel left to convert.

  // Lowest set bit picks the next channel, giving ascending order and
  // skipping unselected channels at no cost in time.
  always_comb
  begin
    cur_ch = 2'h0;
    for (int i = CH_NUM - 1; i >= 0; i--)
      if (rem_q[i])
        cur_ch = 2'(i);
  end

  wire [CH_NUM-1:0] cur_onehot = CH_NUM'(1) << cur_ch;
  wire              converting = (state_q == adcsq_pkg::ADCSQ_CONVERT);
  wire              last_chan  = ((rem_q & ~cur_onehot) == '0);
  // Only a start that the idle sequencer takes may clear the timer or move
  // the pointer, so a start while busy or with no channel changes nothing.
  wire              start_take = start_edge & ~converting & (sel_mask != '0);

  adcsq_conv_timer #(.CYCLES(CONV_CLKS)) u_timer
  (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (start_take),
    .run   (converting),
    .tick  (conv_tick),
    .done  (chan_done)
  );

  // Next-state logic; an empty selection converts nothing and stays idle.
  always_comb
  begin
    state_d = state_q;
    rem_d   = rem_q;
    nres_d  = nres_q;
    case (state_q)
      adcsq_pkg::ADCSQ_IDLE:
      begin
        if (start_take)
        begin
          rem_d   = sel_mask;
          nres_d  = 3'h0;
          state_d = adcsq_pkg::ADCSQ_CONVERT;
        end
      end
      adcsq_pkg::ADCSQ_CONVERT:
      begin
        if (chan_done)
        begin
          rem_d  = rem_q & ~cur_onehot;
          nres_d = nres_q + 3'h1;
          if (last_chan)
            state_d = adcsq_pkg::ADCSQ_IDLE;
        end
      end
      default:
        state_d = adcsq_pkg::ADCSQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= adcsq_pkg::ADCSQ_IDLE;
      rem_q   <= '0;
      nres_q  <= 3'h0;
      eoc_n_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      rem_q   <= rem_d;
      nres_q  <= nres_d;
      eoc_n_q <= ~(converting & chan_done);
    end
  end

  // ----------------------------------------------------------------------
  // Result store and output pointer
  // ----------------------------------------------------------------------
  // Results sit in conversion order so the pointer walks only real data.
  logic [DATA_W-1:0] res_q [CH_NUM];
  logic [1:0]        ptr_q;
  logic [DATA_W-1:0] dout_q;
  wire               ptr_wrap = ({1'b0, ptr_q} + 3'h1) >= nres_q;

  always_ff @(posedge clk)
  begin
    if (converting && chan_done)
      res_q[nres_q[1:0]] <= sample_code;
  end

  // A new start wins over a read that ends in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_q <= `ADCSQ_FIRST_SLOT;
    else if (start_take)
      ptr_q <= `ADCSQ_FIRST_SLOT;
    else if (read_end)
      ptr_q <= ptr_wrap ? `ADCSQ_FIRST_SLOT : ptr_q + 2'h1;
  end

  // Output data is registered from the slot under the pointer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dout_q <= '0;
    else
      dout_q <= res_q[ptr_q];
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign data_out          = dout_q;
  assign data_oe           = ~cs_s & ~rd_s;
  assign busy              = converting;
  assign eoc_n             = eoc_n_q;
  assign first_result_flag = (ptr_q == `ADCSQ_FIRST_SLOT);
  assign track_hold_hold   = converting;
  assign active_channel    = cur_ch;
  assign standby_active    = ~standby_n_n_s;

endmodule : adcsq_top

// ---- adcsq_assertions.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Port checker of the sequencer and host port
// ----------------------------------------------------------------------
module adcsq_assertions
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic standby_n,
  input wire logic data_oe,
  input wire logic busy,
  input wire logic eoc_n,
  input wire logic first_result_flag,
  input wire logic track_hold_hold,
  input wire logic standby_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles since the last start edge and the last selected read end.
  logic [2:0] start_age_q;
  logic [2:0] rd_age_q;
  // Ages saturate at seven, so a stale edge can never look fresh.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      start_age_q <= 3'h7;
      rd_age_q    <= 3'h7;
    end
    else
    begin
      start_age_q <= $rose(conversion_start_n) ? 3'h0 : start_age_q + {2'h0, start_age_q != 3'h7};
      rd_age_q    <= ($rose(rd_n) && !cs_n) ? 3'h0 : rd_age_q + {2'h0, rd_age_q != 3'h7};
    end
  end
  // One finished channel: a single low cycle.
  sequence s_eoc_pulse;
    !eoc_n ##1 eoc_n;
  endsequence
  chk_busy_cause: assert property ($rose(busy) |-> start_age_q <= 3'h5)
    else $error("busy rose with no start edge");
  chk_busy_end: assert property ($fell(busy) |-> !eoc_n || !$past(eoc_n) || !$past(eoc_n, 2))
    else $error("busy fell away from the last channel end");
  chk_hold_busy: assert property (track_hold_hold == busy)
    else $error("track and hold differs from busy");
  chk_eoc_width: assert property ($fell(eoc_n) |-> s_eoc_pulse)
    else $error("end of conversion pulse not one cycle");
  chk_eoc_in_seq: assert property (!eoc_n |-> busy || $past(busy))
    else $error("end of conversion outside a sequence");
  chk_oe_on: assert property ((!cs_n && !rd_n) [*4] |-> data_oe)
    else $error("data outputs not enabled during read");
  chk_oe_off: assert property ((cs_n || rd_n) [*4] |-> !data_oe)
    else $error("data outputs enabled without read");
  chk_first_start: assert property ($rose(busy) |-> ##[0:2] first_result_flag)
    else $error("pointer not back at first slot after start");
  chk_first_drop: assert property ($fell(first_result_flag) |-> rd_age_q <= 3'h6)
    else $error("pointer left first slot without a read");
  chk_standby_on: assert property ((!standby_n) [*4] |-> standby_active)
    else $error("standby not entered");
  chk_standby_off: assert property (standby_n [*4] |-> !standby_active)
    else $error("standby not left");
endmodule : adcsq_assertions

// ---- adcsq_host_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Host processor on the parallel bus
// ----------------------------------------------------------------------
module adcsq_host_model
(
  input  wire logic        clk,
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [3:0]       data_bus_low_nibble
);
  // Bus idles deselected with both strobes high.
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_bus_low_nibble = 4'h5;
  end
  // Write cycle; sel_n high makes a deselected write that must be ignored.
  task automatic write_csr(input logic sel_n, input logic [3:0] val);
    @(posedge clk);
    cs_n <= sel_n;
    data_bus_low_nibble <= val;
    wr_n <= 1'b0;
    repeat (3) @(posedge clk);
    wr_n <= 1'b1;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    // A released bus shows no stale data.
    data_bus_low_nibble <= ~val;
    repeat (5) @(posedge clk);
  endtask : write_csr
  // Read cycle; the write strobe stays high throughout.
  task automatic read_word(input logic sel_n, output logic [11:0] val, output logic oe);
    @(posedge clk);
    cs_n <= sel_n;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    val = data_out;
    oe  = data_oe;
    rd_n <= 1'b1;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : read_word
endmodule : adcsq_host_model

// ---- test_adc_sequence_host_port.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Bench of the sequencer and host port
// ----------------------------------------------------------------------
module test_adc_sequence_host_port;
  logic clk, resetn, conversion_start_n, cs_n, rd_n, wr_n, hw_sw_select, standby_n;
  logic clock_source_select, external_conversion_clock, ext_run, data_oe, busy, eoc_n;
  logic first_result_flag, track_hold_hold, standby_active;
  logic [3:0]  hw_channel_select, data_bus_low_nibble;
  logic [11:0] sample_code, data_out;
  logic [1:0]  active_channel, ext_div;
  int          n_mismatch, comparisons, cycles, n, gap, k;
  // Short counts keep the run brief: a channel is 12 internal or 24 external clocks.
  adcsq_top #(.CONV_CLKS(3), .INT_DIV(4)) adcsq_top_i (.clk(clk), .resetn(resetn),
    .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .hw_channel_select(hw_channel_select), .hw_sw_select(hw_sw_select),
    .standby_n(standby_n), .clock_source_select(clock_source_select),
    .external_conversion_clock(external_conversion_clock),
    .data_bus_low_nibble(data_bus_low_nibble), .sample_code(sample_code),
    .data_out(data_out), .data_oe(data_oe), .busy(busy), .eoc_n(eoc_n),
    .first_result_flag(first_result_flag), .track_hold_hold(track_hold_hold),
    .active_channel(active_channel), .standby_active(standby_active));
  adcsq_host_model adcsq_host_model_i (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_bus_low_nibble(data_bus_low_nibble));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Converter core: the code names the channel it came from.
  always @(posedge clk)
  begin
    sample_code <= 12'ha50 | {10'h0, active_channel};
    ext_div <= ext_div + 2'h1;
    // The external clock only runs while a scenario asks for it.
    if (ext_run && ext_div == 2'h3)
      external_conversion_clock <= ~external_conversion_clock;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : cmp_range
  // Start edge, pins moved right after it; counts channel ends and their spacing.
  task automatic run_seq(input logic [3:0] pins_after, output int cnt, output int dt);
    int t;
    int t0;
    cnt = 0;
    dt = 0;
    t0 = 0;
    @(posedge clk);
    conversion_start_n <= 1'b1;
    repeat (4) @(posedge clk);
    conversion_start_n <= 1'b0;
    hw_channel_select <= pins_after;
    for (t = 0; t < 600 && !(busy === 1'b0 && t > 8); t++)
    begin
      @(posedge clk);
      #1;
      if (eoc_n === 1'b0)
      begin
        if (cnt == 1)
          dt = t - t0;
        t0 = t;
        cnt++;
      end
    end
  endtask : run_seq
  // Selected read with the first-slot flag checked before it.
  task automatic read_chk(input logic [11:0] exp, input logic first_exp);
    logic [11:0] v;
    logic        oe;
    cmp_bit(first_result_flag, first_exp);
    adcsq_host_model_i.read_word(1'b0, v, oe);
    cmp_word(v, exp);
    cmp_bit(oe, 1'b1);
  endtask : read_chk
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    logic [11:0] v;
    logic        oe;
    {resetn, conversion_start_n, hw_sw_select, clock_source_select} = 4'h0;
    {external_conversion_clock, ext_run, ext_div, hw_channel_select} = 8'h0;
    standby_n = 1'b1;
    sample_code = 12'h0;
    {n_mismatch, comparisons, cycles} = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    cmp_bit(busy, 1'b0);
    cmp_bit(eoc_n, 1'b1);
    cmp_bit(data_oe, 1'b0);
    cmp_bit(first_result_flag, 1'b1);
    // Pins select all four; moving them mid-run must not matter.
    @(posedge clk);
    hw_channel_select <= 4'hf;
    run_seq(4'h1, n, gap);
    cmp_range(n, 4, 4);
    cmp_range(gap, 9, 15);
    adcsq_host_model_i.read_word(1'b1, v, oe);
    cmp_bit(oe, 1'b0);
    for (k = 0; k < 4; k++)
      read_chk(12'ha50 | k[11:0], k == 0);
    cmp_bit(first_result_flag, 1'b1);
    // Register picks channels two and four; a deselected write is ignored.
    adcsq_host_model_i.write_csr(1'b0, 4'ha);
    adcsq_host_model_i.write_csr(1'b1, 4'h1);
    hw_sw_select <= 1'b1;
    run_seq(4'h1, n, gap);
    cmp_range(n, 2, 2);
    read_chk(12'ha51, 1'b1);
    read_chk(12'ha53, 1'b0);
    // External conversion clock, and a restart with the pointer mid-way.
    clock_source_select <= 1'b1;
    ext_run <= 1'b1;
    run_seq(4'h1, n, gap);
    cmp_range(gap, 17, 31);
    read_chk(12'ha51, 1'b1);
    run_seq(4'h1, n, gap);
    read_chk(12'ha51, 1'b1);
    ext_run <= 1'b0;
    // Standby refuses a start.
    standby_n <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    cmp_bit(standby_active, 1'b1);
    run_seq(4'h1, n, gap);
    cmp_range(n, 0, 0);
    cmp_bit(busy, 1'b0);
    wrap_up();
  end
endmodule : test_adc_sequence_host_port
bind adcsq_top adcsq_assertions adcsq_assertions_i (.clk(clk), .resetn(resetn),
  .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
  .standby_n(standby_n), .data_oe(data_oe), .busy(busy), .eoc_n(eoc_n),
  .first_result_flag(first_result_flag), .track_hold_hold(track_hold_hold),
  .standby_active(standby_active));
